// ===== adc_capture_cfg.svh
`ifndef ADC_CAPTURE_CFG_SVH
`define ADC_CAPTURE_CFG_SVH
// Operation
// - converter forwards data clock; receiver samples it with mclk and finds its edges
// - divider reset driven from datapath clock logic
// - divider reset also empties the crossing FIFO
// - FIFO writes 16-bit words, reads 32-bit pairs
// - words carry two signal paths, reads two samples per path
// - first word after reset fills low half
// - reading held off until fill threshold reached
// - locked while fill level stays constant reading
// - empty or overflow reports not locked
// - supervisor restarts fill-then-read until locked again
// - FIFO reset enters write side through capture flop
// - used-words count crosses through capture register
// - datapath clock phase shifted 156 ps
// - per-bit input delay tap, clock undelayed
// - delay taps fixed at build, no control
// - both divider reset output taps zero
// - samples captured on both data clock edges by mclk edge detection

// register byte offsets
`define CTRL_ADDR        8'h00
`define STATUS_ADDR      8'h04
`define CONFIG_ADDR      8'h08
`define TAPS_ADDR        8'h0c

// control fields
`define CTRL_TRIGGER_BIT 0
`define CTRL_THRESH_LSB  8
`define CTRL_THRESH_MSB  15
`define THRESH_RESET     8'h08

// status fields
`define STAT_LOCKED_BIT  0
`define STAT_READING_BIT 1
`define STAT_OVF_BIT     2
`define STAT_UNF_BIT     3
`define STAT_USED_LSB    8
`define STAT_USED_MSB    15

// timing
`define MCLK_PERIOD_PS   8000
`define DIV_RST_TIME_NS  32
`define DIV_RST_CYCLES   ((`DIV_RST_TIME_NS * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS)
`define DP_PHASE_PS      156
`define SETTLE_CYCLES    3'h4

// build-time pin delay taps
`define IN_TAP_VECTOR    32'h22222222
`define OUT_TAP_A        4'h0
`define OUT_TAP_B        4'h0

`endif

// ===== adc_capture_pkg.sv
package adc_capture_pkg;

  typedef enum logic [1:0] {LOCK_FLUSH, LOCK_FILL, LOCK_READ} lock_state_type;

  typedef logic [7:0] sample_type;

endpackage

// ===== ddr_pair_receiver.sv
`timescale 1ns/1ps
`include "adc_capture_cfg.svh"
module ddr_pair_receiver (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // converter lane
  input  wire logic                      data_clock,
  input  wire adc_capture_pkg::sample_type lane_data,
  input  wire logic                      hold,
  // write word
  output logic [15:0]                    word,
  output logic                           word_valid
);

  typedef struct packed {
    logic                        prev_clk;
    logic                        have_sp0;
    adc_capture_pkg::sample_type sp0;
    logic [15:0]                 word;
    logic                        valid;
  } rx_state_type;

  rx_state_type st;
  rx_state_type next_st;

  always_comb begin
    next_st          = st;
    next_st.prev_clk = data_clock;
    next_st.valid    = 1'b0;
    if (hold) begin
      // clock is stopped during divider reset, drop any half pair
      next_st.have_sp0 = 1'b0;
    end else if (data_clock && !st.prev_clk) begin
      next_st.sp0      = lane_data; // rising half: signal path 0
      next_st.have_sp0 = 1'b1;
    end else if (!data_clock && st.prev_clk && st.have_sp0) begin
      next_st.word     = {lane_data, st.sp0}; // one sample per path
      next_st.valid    = 1'b1;
      next_st.have_sp0 = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word       = st.word;
  assign word_valid = st.valid;

  chk_ddr_pair: assert property (@(posedge mclk) disable iff (rst)
    word_valid |-> ($past(st.prev_clk) && !$past(data_clock)
                    && word[15:8] == $past(lane_data)))
    else $error("word not built on a falling data clock edge");

endmodule

// ===== fifo_lock_supervisor.sv
`timescale 1ns/1ps
`include "adc_capture_cfg.svh"
module fifo_lock_supervisor (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // fifo status
  input  wire logic       restart,
  input  wire logic [7:0] used,
  input  wire logic [7:0] threshold,
  input  wire logic       read_tick,
  input  wire logic       overflow,
  input  wire logic       underflow,
  // control and status
  output logic            read_enable,
  output logic            flush,
  output logic            locked
);

  typedef struct packed {
    adc_capture_pkg::lock_state_type state;
    logic [2:0]                      settle;
    logic [7:0]                      ref_level;
    logic                            ref_valid;
    logic                            read_enable;
    logic                            flush;
    logic                            locked;
  } sup_state_type;

  sup_state_type st;
  sup_state_type next_st;

  always_comb begin
    next_st       = st;
    next_st.flush = 1'b0;
    case (st.state)
      adc_capture_pkg::LOCK_FLUSH: begin
        next_st.flush       = (st.settle == 3'h0);
        next_st.settle      = st.settle + 3'h1;
        next_st.ref_valid   = 1'b0;
        next_st.locked      = 1'b0;
        next_st.read_enable = 1'b0;
        if (st.settle == `SETTLE_CYCLES) begin
          next_st.state = adc_capture_pkg::LOCK_FILL;
        end
      end
      adc_capture_pkg::LOCK_FILL: begin
        if (used >= threshold) begin
          next_st.state       = adc_capture_pkg::LOCK_READ;
          next_st.read_enable = 1'b1;
        end
      end
      adc_capture_pkg::LOCK_READ: begin
        if (overflow || underflow) begin
          next_st.state       = adc_capture_pkg::LOCK_FLUSH;
          next_st.settle      = 3'h0;
          next_st.locked      = 1'b0;
          next_st.read_enable = 1'b0;
        end else if (read_tick) begin
          if (!st.ref_valid) begin
            next_st.ref_level = used;
            next_st.ref_valid = 1'b1;
            next_st.locked    = 1'b1;
          end else if (used != st.ref_level) begin
            next_st.state       = adc_capture_pkg::LOCK_FLUSH;
            next_st.settle      = 3'h0;
            next_st.locked      = 1'b0;
            next_st.read_enable = 1'b0;
          end
        end
      end
      default: begin
        next_st.state  = adc_capture_pkg::LOCK_FLUSH;
        next_st.settle = 3'h0;
      end
    endcase
    if (restart) begin
      next_st.state       = adc_capture_pkg::LOCK_FLUSH;
      next_st.settle      = 3'h0;
      next_st.locked      = 1'b0;
      next_st.read_enable = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '{adc_capture_pkg::LOCK_FLUSH, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign read_enable = st.read_enable;
  assign flush       = st.flush;
  assign locked      = st.locked;

  chk_fill_gate: assert property (@(posedge mclk) disable iff (rst)
    (st.state == adc_capture_pkg::LOCK_FILL && used < threshold) |=> !st.read_enable)
    else $error("reading enabled below fill threshold");

  chk_locked_reading: assert property (@(posedge mclk) disable iff (rst)
    st.locked |-> (st.state == adc_capture_pkg::LOCK_READ && st.read_enable && st.ref_valid))
    else $error("locked reported outside reading");

  chk_loss_restart: assert property (@(posedge mclk) disable iff (rst)
    (st.state == adc_capture_pkg::LOCK_READ && (overflow || underflow) && !restart)
    |=> (!st.locked && st.state == adc_capture_pkg::LOCK_FLUSH) ##1 st.flush)
    else $error("loss of lock did not restart the fill sequence");

endmodule

// ===== adc_sample_capture_cdc.sv
`timescale 1ns/1ps
`include "adc_capture_cfg.svh"
module adc_sample_capture_cdc #(
  parameter int          DEPTH                  = 16,
  parameter int          DP_DIV                 = 4,
  parameter int          datapath_phase_generic = `DP_PHASE_PS,
  parameter logic [31:0] INPUT_DELAY_TAP        = `IN_TAP_VECTOR
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // converter link
  input  wire logic                        data_clock,
  input  wire adc_capture_pkg::sample_type lane_data,
  output logic                             divider_reset,
  // datapath output
  output logic [31:0]                      sample_data,
  output logic                             sample_valid,
  output logic                             locked
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic                   dp_sel;
    logic                   dp_write;
    logic [7:0]             dp_addr;
    logic                   hreadyout;
    logic                   hresp;
    logic [31:0]            hrdata;
    logic [7:0]             threshold;
    logic [3:0]             rst_cnt;
    logic                   divider_reset;
    logic                   wr_rst_cap;
    logic [AW:0]            wr_ptr;
    logic [AW:0]            rd_ptr;
    logic [DEPTH-1:0][15:0] mem;
    logic [7:0]             used_cap;
    logic [7:0]             dp_cnt;
    logic                   read_tick;
    logic [31:0]            sample_data;
    logic                   sample_valid;
    logic                   ovf_pulse;
    logic                   unf_pulse;
    logic                   ovf_seen;
    logic                   unf_seen;
  } top_state_type;

  top_state_type st;
  top_state_type next_st;

  logic [15:0]   rx_word;
  logic          rx_valid;
  logic          sup_read_en;
  logic          sup_flush;
  logic          sup_locked;
  logic [AW:0]   used;
  logic          clear_req;
  logic [AW-1:0] rd_lo;
  logic [AW-1:0] rd_hi;
  logic          unused_hsize;

  assign used         = st.wr_ptr - st.rd_ptr;
  // divider reset or a supervisor restart empties the fifo
  assign clear_req    = st.divider_reset | sup_flush;
  assign rd_lo        = st.rd_ptr[AW-1:0];
  assign rd_hi        = {rd_lo[AW-1:1], 1'b1};
  assign unused_hsize = ^hsize;

  ddr_pair_receiver receiver (
    .mclk       (mclk),
    .rst        (rst),
    .data_clock (data_clock),
    .lane_data  (lane_data),
    .hold       (st.divider_reset),
    .word       (rx_word),
    .word_valid (rx_valid)
  );

  fifo_lock_supervisor supervisor (
    .mclk        (mclk),
    .rst         (rst),
    .restart     (st.divider_reset),
    .used        (st.used_cap),
    .threshold   (st.threshold),
    .read_tick   (st.read_tick),
    .overflow    (st.ovf_pulse),
    .underflow   (st.unf_pulse),
    .read_enable (sup_read_en),
    .flush       (sup_flush),
    .locked      (sup_locked)
  );

  function automatic logic [31:0] reg_read(input logic [7:0] addr);
    logic [31:0] value;
    value = 32'h0000_0000;
    case (addr)
      `CTRL_ADDR: begin
        value[`CTRL_THRESH_MSB:`CTRL_THRESH_LSB] = st.threshold;
        value[`CTRL_TRIGGER_BIT]                 = st.divider_reset;
      end
      `STATUS_ADDR: begin
        value[`STAT_LOCKED_BIT]               = sup_locked;
        value[`STAT_READING_BIT]              = sup_read_en;
        value[`STAT_OVF_BIT]                  = st.ovf_seen;
        value[`STAT_UNF_BIT]                  = st.unf_seen;
        value[`STAT_USED_MSB:`STAT_USED_LSB]  = st.used_cap;
      end
      `CONFIG_ADDR: begin
        // build-time settings, read only
        value = {4'h0, `OUT_TAP_B, 4'h0, `OUT_TAP_A, 16'(datapath_phase_generic)};
      end
      `TAPS_ADDR: begin
        // one tap per sample bit, none on the data clock
        value = INPUT_DELAY_TAP;
      end
      default: begin
        value = 32'h0000_0000;
      end
    endcase
    return value;
  endfunction

  always_comb begin
    next_st              = st;
    next_st.hreadyout    = 1'b1;
    next_st.hresp        = 1'b0;
    next_st.hrdata       = 32'h0000_0000;
    next_st.ovf_pulse    = 1'b0;
    next_st.unf_pulse    = 1'b0;
    next_st.sample_valid = 1'b0;

    // divider reset pulse count, all in the datapath clock domain
    if (st.rst_cnt != 4'h0) begin
      next_st.rst_cnt = st.rst_cnt - 4'h1;
    end

    // bus data phase
    if (st.dp_sel && st.dp_write) begin
      case (st.dp_addr)
        `CTRL_ADDR: begin
          next_st.threshold = hwdata[`CTRL_THRESH_MSB:`CTRL_THRESH_LSB];
          if (hwdata[`CTRL_TRIGGER_BIT]) begin
            // restarts the converter divider at a known phase
            next_st.rst_cnt = 4'(`DIV_RST_CYCLES);
          end
        end
        `STATUS_ADDR: begin
          if (hwdata[`STAT_OVF_BIT]) begin
            next_st.ovf_seen = 1'b0;
          end
          if (hwdata[`STAT_UNF_BIT]) begin
            next_st.unf_seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // bus address phase
    next_st.dp_sel = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_st.dp_sel   = (haddr[31:8] == 24'h00_0000);
      next_st.dp_write = hwrite;
      next_st.dp_addr  = haddr[7:0];
      if (!hwrite && haddr[31:8] == 24'h00_0000) begin
        next_st.hrdata = reg_read(haddr[7:0]);
      end
    end

    next_st.divider_reset = (next_st.rst_cnt != 4'h0);
    next_st.wr_rst_cap    = clear_req;
    next_st.used_cap      = 8'(used);

    // datapath rate enable
    next_st.read_tick = (st.dp_cnt == 8'(DP_DIV - 1));
    if (st.dp_cnt == 8'(DP_DIV - 1)) begin
      next_st.dp_cnt = 8'h00;
    end else begin
      next_st.dp_cnt = st.dp_cnt + 8'h01;
    end

    // write side, held in reset by the captured clear
    if (st.wr_rst_cap) begin
      next_st.wr_ptr = '0;
    end else if (rx_valid) begin
      if (used == (AW+1)'(DEPTH)) begin
        next_st.ovf_pulse = 1'b1;
      end else begin
        next_st.mem[st.wr_ptr[AW-1:0]] = rx_word;
        next_st.wr_ptr                 = st.wr_ptr + 1'b1;
      end
    end

    // read side, two words per read, the older one in the low half
    if (clear_req || st.wr_rst_cap) begin
      next_st.rd_ptr = '0;
    end else if (st.read_tick && sup_read_en) begin
      if (used < (AW+1)'(2)) begin
        next_st.unf_pulse = 1'b1;
      end else begin
        next_st.sample_data  = {st.mem[rd_hi], st.mem[rd_lo]};
        next_st.sample_valid = 1'b1;
        next_st.rd_ptr       = st.rd_ptr + (AW+1)'(2);
      end
    end

    // sticky flags, a new event wins over the clear
    if (st.ovf_pulse) begin
      next_st.ovf_seen = 1'b1;
    end
    if (st.unf_pulse) begin
      next_st.unf_seen = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st           <= '0;
      st.threshold <= `THRESH_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout     = st.hreadyout;
  assign hresp         = st.hresp;
  assign hrdata        = st.hrdata;
  assign divider_reset = st.divider_reset;
  assign sample_data   = st.sample_data;
  assign sample_valid  = st.sample_valid;
  assign locked        = sup_locked;

  chk_div_rst_len: assert property (@(posedge mclk) disable iff (rst)
    ($rose(st.divider_reset) && !(st.dp_sel && st.dp_write))
    |-> st.divider_reset[*4] ##1 !st.divider_reset)
    else $error("divider reset pulse length wrong");

  chk_fifo_cleared: assert property (@(posedge mclk) disable iff (rst)
    st.divider_reset |-> ##2 (st.wr_ptr == '0 && st.rd_ptr == '0))
    else $error("fifo not emptied by divider reset");

  chk_overflow_flag: assert property (@(posedge mclk) disable iff (rst)
    (!st.wr_rst_cap && rx_valid && used == (AW+1)'(DEPTH))
    |=> st.ovf_pulse ##1 st.ovf_seen)
    else $error("overflow not flagged");

  chk_underflow_flag: assert property (@(posedge mclk) disable iff (rst)
    (!clear_req && !st.wr_rst_cap && st.read_tick && sup_read_en && used < (AW+1)'(2))
    |=> (st.unf_pulse && !st.sample_valid) ##1 st.unf_seen)
    else $error("empty read not flagged");

  chk_read_step: assert property (@(posedge mclk) disable iff (rst)
    (!clear_req && !st.wr_rst_cap && st.read_tick && sup_read_en && used >= (AW+1)'(2))
    |=> (st.sample_valid && st.rd_ptr == (AW+1)'($past(st.rd_ptr) + 2)
         && st.sample_data[15:0] == $past(st.mem[rd_lo])))
    else $error("read did not return the next word pair");

endmodule

// ===== adc_link_model.sv
`timescale 1ns/1ps
module adc_link_model #(
  parameter int RESUME_GAP = 8
) (
  // clock
  input  wire logic                        mclk,
  // control from receiver and bench
  input  wire logic                        divider_reset,
  input  wire logic                        run,
  input  wire logic [7:0]                  seed,
  // converter link
  output logic                             data_clock,
  output adc_capture_pkg::sample_type      lane_data
);
  logic [7:0] n;
  int         gap;

  initial begin
    // divider phase is arbitrary until the first divider reset
    data_clock = seed[0];
    lane_data  = 8'h5a;
    n          = 8'h00;
    gap        = 0;
  end

  always @(posedge mclk) begin
    if (divider_reset) begin
      // clock stands still, counter restarts at a defined phase
      data_clock <= 1'b0;
      lane_data  <= ~lane_data;
      n          <= seed;
      gap        <= RESUME_GAP;
    end else if (gap > 0 || !run) begin
      // no edges: data line carries no valid sample
      if (gap > 0) gap <= gap - 1;
      lane_data <= ~lane_data;
    end else if (!data_clock) begin
      // rising edge carries path 0 with the forwarded clock
      data_clock <= 1'b1;
      lane_data  <= n;
    end else begin
      // falling edge carries path 1
      data_clock <= 1'b0;
      lane_data  <= ~n;
      n          <= n + 8'h01;
    end
  end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "adc_capture_cfg.svh"
module tb_top;
  localparam int GAP = 8;
  logic                        mclk = 1'b0, rst = 1'b1;
  logic                        hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]                 haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]                  htrans = 2'b00;
  logic [2:0]                  hsize = 3'b010;
  logic                        hreadyout, hresp, divider_reset, sample_valid, locked;
  logic [31:0]                 hrdata, sample_data;
  logic                        data_clock, run = 1'b0, rd_ph = 1'b0, wait_first = 1'b0;
  logic [7:0]                  seed_b = 8'h00;
  adc_capture_pkg::sample_type lane_data;
  logic [63:0]                 rq[$];
  logic [31:0]                 sq[$];
  int                          bad_count = 0, checks_done = 0, seed = 88, cyc = 0;
  int                          plen = 0, t_first = 0, lo = 0, i, k, thr;

  always #4 mclk = ~mclk;

  adc_sample_capture_cdc u_adc_sample_capture_cdc (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .data_clock(data_clock), .lane_data(lane_data),
    .divider_reset(divider_reset), .sample_data(sample_data),
    .sample_valid(sample_valid), .locked(locked));

  adc_link_model #(.RESUME_GAP(GAP)) u_adc_link_model (
    .mclk(mclk), .divider_reset(divider_reset), .run(run), .seed(seed_b),
    .data_clock(data_clock), .lane_data(lane_data));

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask

  task automatic reg_read(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e});
    ahb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] exp_word(input logic [7:0] s, input int n);
    logic [7:0] a;
    logic [7:0] b;
    a = s + 8'(2 * n);
    b = a + 8'h01;
    return {~b, b, ~a, a};
  endfunction

  // watcher: register data phases, pulse length, first read, sample stream
  always @(posedge mclk) begin
    if (rd_ph && hreadyout === 1'b1 && rq.size() > 0) begin
      check_word(hrdata & rq[0][63:32], rq[0][31:0]);
      check_flag(hresp, 1'b0);
      void'(rq.pop_front());
    end
    rd_ph <= hsel && hreadyout && htrans[1] && !hwrite;
    if (divider_reset === 1'b1) begin
      plen       <= plen + 1;
      t_first    <= 0;
      wait_first <= 1'b1;
    end else begin
      if (plen != 0) check_word(32'(plen), 32'(`DIV_RST_CYCLES));
      plen <= 0;
      if (wait_first) t_first <= t_first + 1;
    end
    if (sample_valid === 1'b1) begin
      if (wait_first && !divider_reset) begin
        check_flag(t_first >= lo && t_first <= lo + 24, 1'b1);
        wait_first <= 1'b0;
      end
      if (sq.size() > 0) check_word(sample_data, sq.pop_front());
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    run <= 1'b1;
    repeat (2) @(posedge mclk);
    reg_read(32'h0, 32'h0000_0800, 32'hffff_ffff);
    reg_read(32'h8, 32'h0000_009c, 32'hffff_ffff);
    reg_read(32'hc, 32'h2222_2222, 32'hffff_ffff);
    ahb(1'b1, 32'hc, 32'h0);
    reg_read(32'hc, 32'h2222_2222, 32'hffff_ffff);
    reg_read(32'h10, 32'h0, 32'hffff_ffff);
    reg_read(32'h104, 32'h0, 32'hffff_ffff);
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      thr    = 4 + ($random(seed) & 7);
      seed_b <= 8'($random(seed));
      lo     = GAP + 2 * thr;
      ahb(1'b1, 32'h0, {16'h0, 8'(thr), 8'h01});
      // wait for the pulse to start and end, so no read of the old stream is matched
      for (k = 0; k < 50 && divider_reset !== 1'b1; k++) @(posedge mclk);
      for (k = 0; k < 50 && divider_reset !== 1'b0; k++) @(posedge mclk);
      for (k = 0; k < 6; k++) sq.push_back(exp_word(seed_b, k));
      for (k = 0; k < 300 && sq.size() > 0; k++) @(posedge mclk);
      check_word(32'(sq.size()), 32'h0);
      repeat (32) begin
        @(posedge mclk);
        check_flag(locked, 1'b1);
      end
      reg_read(32'h4, 32'h3, 32'h3);
      $display("test lock pass %0d threshold %0d done", i, thr);
    end
    run <= 1'b0;
    for (k = 0; k < 200 && locked !== 1'b0; k++) @(posedge mclk);
    check_flag(locked, 1'b0);
    repeat (20) @(posedge mclk);
    run <= 1'b1;
    for (k = 0; k < 600 && locked !== 1'b1; k++) @(posedge mclk);
    check_flag(locked, 1'b1);
    reg_read(32'h4, 32'h3, 32'h3);
    $display("test stall and relock done");
    repeat (4) @(posedge mclk);
    finish_test;
  end
endmodule
